// ---- shared/iag_pkg.sv ----
`default_nettype none
package iag_pkg;
  // Five status/enable/clear sets, one control word, one receive word
  localparam int NSETS = 5;
  localparam logic [2:0] NO_SET = 3'h7;
  localparam logic [11:0] STAT_BASE = 12'h100;
  localparam logic [11:0] EN_BASE = 12'h118;
  localparam logic [11:0] CTRL_OFF = 12'h12C;
  localparam logic [11:0] RXHOLD_OFF = 12'h1FC;
  localparam logic [11:0] SET_STRIDE = 12'h004;
  // First status word event positions
  localparam int B_FRAME = 31;
  localparam int B_DISP = 30;
  localparam int B_TDM_HALF = 29;
  localparam int B_TDM_END = 28;
  localparam int B_TDM_STEP = 27;
  localparam int B_IN_A = 26;
  localparam int B_IN_B = 25;
  localparam int B_CLK_ACT = 24;
  localparam int B_OVERRUN = 23;
  localparam int B_AUD_HALF = 22;
  localparam int B_AUD_END = 21;
  localparam int B_VOICE_HALF = 20;
  localparam int B_OTHER_LSB = 5;
  localparam logic [31:0] STAT1_MASK = 32'hFFFF_FFE0;
  // Control word fields
  localparam int C_GEN = 31;
  localparam int C_HREQ = 30;
  localparam int C_LREQ = 29;
  localparam int C_VEC_LSB = 16;
  // Values after reset
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] EN_RST = 32'h0000_0000;
  localparam logic GEN_RST = 1'b0;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [31:0] RX_RST = 32'h0000_0000;
endpackage : iag_pkg
`default_nettype wire

// ---- src/iag_interrupt_aggregator.sv ----
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Events set readable sticky status bits
// - Pins give separate rise and fall bits
// - Per-bit read/write enable gates status
// - Low request is enabled OR times global
// - Writing one clears status, zero ignored
// - Clear shares status address and bit
// - Reset clears the global enable
// - Status held cleared throughout reset
// - Sixteen-bit priority mask, bit 15 highest
// - Masked high sources ORed into request
// - Overall request is high or low
// - Encoder gives highest pending level, 0 default
// - High drives int4, cond3; low int2
// - Five sets plus one control word
// - Frame end bit 31, alternation bit 30
// - TDM half 29, end 28, step 27
// - Input half A 26, half B 25
// - Link clock activity sets bit 24
// - Receive or transmit lag sets bit 23
// - Audio half 22, end 21, voice 20
// - Read returns half named by last event
// - Bytes 3..0 land in lanes 31..0
module iag_interrupt_aggregator
  import iag_pkg::*;
#(
  parameter int NUM_PINS = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Event pulses, first set then sets two to five
  input wire logic frame_end_event_i,
  input wire logic display_alternation_event_i,
  input wire logic tdm_buffer_half_event_i,
  input wire logic tdm_buffer_end_event_i,
  input wire logic tdm_pointer_step_event_i,
  input wire logic tdm_overrun_event_i,
  input wire logic audio_buffer_half_event_i,
  input wire logic audio_buffer_end_event_i,
  input wire logic voice_buffer_half_event_i,
  input wire logic [19:5] set1_other_event_i,
  input wire logic [4*32-1:0] sets2_5_event_i,
  // Asynchronous pins
  input wire logic [NUM_PINS-1:0] ext_pin_i,
  input wire logic tdm_link_clock_i,
  // TDM receive side
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_byte_valid_i,
  input wire logic [1:0] rx_byte_lane_i,
  input wire logic rx_byte_half_b_i,
  input wire logic tdm_input_half_a_event_i,
  input wire logic tdm_input_half_b_event_i,
  input wire logic dma_rx_take_i,
  output logic [31:0] tdm_rx_hold_word_o,
  // High-priority sources 15..1
  input wire logic [15:1] hp_src_i,
  // Processor requests
  output logic cpu_int4_o,
  output logic cpu_int2_o,
  output logic cop_cond3_o,
  output logic irq_o
);

  function automatic logic [2:0] set_of(input logic [11:0] a, input logic [11:0] base);
    logic [2:0] r;
    r = NO_SET;
    for (int k = 0; k < NSETS; k++) begin
      if (a == base + 12'(k * 4)) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : set_of

  function automatic logic [3:0] top_level(input logic [15:0] g);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 1; k < 16; k++) begin
      if (g[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : top_level

  logic [31:0] stat_q [NSETS];
  logic [31:0] en_q [NSETS];
  logic [31:0] ev [NSETS];
  logic [31:0] clr [NSETS];
  logic gen_q;
  logic [15:0] mask_q;
  logic [31:0] prdata_q;
  logic [31:0] hold_a_q;
  logic [31:0] hold_b_q;
  logic [31:0] rx_word_q;
  logic rx_pend_q;
  logic [NUM_PINS:0] s1_q;
  logic [NUM_PINS:0] s2_q;
  logic [NUM_PINS:0] s3_q;
  logic [NUM_PINS:0] pst_q;
  logic [NUM_PINS:0] agree;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic clk_act;
  logic acc_wr;
  logic acc_rd;
  logic setup_rd;
  logic [2:0] st_idx;
  logic [2:0] en_idx;
  logic hit;
  logic take_now;
  logic rx_overrun;
  logic [15:0] gated_hp;
  logic [3:0] prio_vec;
  logic high_req;
  logic low_any;
  logic low_req;

  // APB decode
  assign acc_wr = psel_i && penable_i && pwrite_i;
  assign acc_rd = psel_i && penable_i && !pwrite_i;
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign st_idx = set_of(paddr_i, STAT_BASE);
  assign en_idx = set_of(paddr_i, EN_BASE);
  assign hit = (st_idx != NO_SET) || (en_idx != NO_SET) || (paddr_i == CTRL_OFF) || (paddr_i == RXHOLD_OFF);
  // Read data is captured in setup, so access never waits
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign prdata_o = prdata_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      if (st_idx != NO_SET) begin
        prdata_q <= stat_q[st_idx];
      end else if (en_idx != NO_SET) begin
        prdata_q <= en_q[en_idx];
      end else if (paddr_i == CTRL_OFF) begin
        prdata_q <= {gen_q, high_req, low_req, 9'h000, prio_vec, mask_q};
      end else if (paddr_i == RXHOLD_OFF) begin
        prdata_q <= rx_word_q;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Three-stage pin sampling; link clock rides as top bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pst_q <= '0;
    end else begin
      s1_q <= {tdm_link_clock_i, ext_pin_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k <= NUM_PINS; k++) begin
        if (agree[k]) begin
          pst_q[k] <= s3_q[k];
        end
      end
    end
  end

  assign agree = ~(s2_q ^ s3_q);
  assign pin_rise = agree[NUM_PINS-1:0] & s3_q[NUM_PINS-1:0] & ~pst_q[NUM_PINS-1:0];
  assign pin_fall = agree[NUM_PINS-1:0] & ~s3_q[NUM_PINS-1:0] & pst_q[NUM_PINS-1:0];
  // link clock activity
  // Only activity is seen; a link clock faster than ours may alias
  assign clk_act = agree[NUM_PINS] && (s3_q[NUM_PINS] != pst_q[NUM_PINS]);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hold_a_q <= RX_RST;
      hold_b_q <= RX_RST;
    end else if (rx_byte_valid_i) begin
      if (rx_byte_half_b_i) begin
        hold_b_q[{rx_byte_lane_i, 3'b000} +: 8] <= rx_byte_i;
      end else begin
        hold_a_q[{rx_byte_lane_i, 3'b000} +: 8] <= rx_byte_i;
      end
    end
  end

  assign take_now = (acc_rd && paddr_i == RXHOLD_OFF) || dma_rx_take_i;
  // new half before old one taken
  assign rx_overrun = (tdm_input_half_a_event_i || tdm_input_half_b_event_i) && rx_pend_q && !take_now;

  // word follows the latest half event
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_q <= RX_RST;
      rx_pend_q <= 1'b0;
    end else begin
      if (tdm_input_half_a_event_i) begin
        rx_word_q <= hold_a_q;
      end else if (tdm_input_half_b_event_i) begin
        rx_word_q <= hold_b_q;
      end
      if (tdm_input_half_a_event_i || tdm_input_half_b_event_i) begin
        rx_pend_q <= 1'b1;
      end else if (take_now) begin
        rx_pend_q <= 1'b0;
      end
    end
  end
  assign tdm_rx_hold_word_o = rx_word_q;

  // Event vectors per set
  always_comb begin
    for (int k = 1; k < NSETS; k++) begin
      ev[k] = sets2_5_event_i[(k-1)*32 +: 32];
    end
    ev[0] = 32'h0000_0000;
    ev[0][19:B_OTHER_LSB] = set1_other_event_i;
    ev[0][B_FRAME] = frame_end_event_i;
    ev[0][B_DISP] = display_alternation_event_i;
    ev[0][B_TDM_HALF] = tdm_buffer_half_event_i;
    ev[0][B_TDM_END] = tdm_buffer_end_event_i;
    ev[0][B_TDM_STEP] = tdm_pointer_step_event_i;
    ev[0][B_IN_A] = tdm_input_half_a_event_i;
    ev[0][B_IN_B] = tdm_input_half_b_event_i;
    ev[0][B_CLK_ACT] = clk_act;
    ev[0][B_OVERRUN] = tdm_overrun_event_i || rx_overrun;
    ev[0][B_AUD_HALF] = audio_buffer_half_event_i;
    ev[0][B_AUD_END] = audio_buffer_end_event_i;
    ev[0][B_VOICE_HALF] = voice_buffer_half_event_i;
    // pin pairs in last set, fall even, rise odd
    for (int k = 0; k < NUM_PINS; k++) begin
      ev[NSETS-1][2*k] = ev[NSETS-1][2*k] | pin_fall[k];
      ev[NSETS-1][2*k+1] = ev[NSETS-1][2*k+1] | pin_rise[k];
    end
  end

  for (genvar g = 0; g < NSETS; g++) begin : g_set
    localparam logic [31:0] M = (g == 0) ? STAT1_MASK : 32'hFFFF_FFFF;
    always_comb begin
      clr[g] = (acc_wr && st_idx == 3'(g)) ? pwdata_i : 32'h0000_0000;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        stat_q[g] <= STAT_RST;
        en_q[g] <= EN_RST;
      end else begin
        stat_q[g] <= ((stat_q[g] & ~clr[g]) | ev[g]) & M;
        if (acc_wr && en_idx == 3'(g)) begin
          en_q[g] <= pwdata_i & M;
        end
      end
    end
  end

  // Control word: global enable and mask
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gen_q <= GEN_RST;
      mask_q <= MASK_RST;
    end else if (acc_wr && paddr_i == CTRL_OFF) begin
      gen_q <= pwdata_i[C_GEN];
      mask_q <= pwdata_i[15:0];
    end
  end

  always_comb begin
    low_any = 1'b0;
    for (int k = 0; k < NSETS; k++) begin
      low_any = low_any | (|(stat_q[k] & en_q[k]));
    end
  end

  assign low_req = low_any && gen_q;
  // masked sources, bit 0 has no source
  assign gated_hp = mask_q & {hp_src_i, 1'b0};
  assign high_req = |gated_hp;
  assign prio_vec = top_level(gated_hp);
  assign cpu_int4_o = high_req;
  assign cop_cond3_o = high_req;
  assign cpu_int2_o = low_req;
  assign irq_o = high_req || low_req;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_stat_set;
    frame_end_event_i |=> stat_q[0][B_FRAME];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("event did not set status");

  property p_pin_rise;
    pin_rise[0] |=> stat_q[NSETS-1][1] && !$past(pin_fall[0]);
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("pin rise not recorded");

  // Recomputed from the registers, independent of the OR loop
  property p_low_gate;
    cpu_int2_o == (gen_q && (((stat_q[0] & en_q[0]) | (stat_q[1] & en_q[1]) | (stat_q[2] & en_q[2])
      | (stat_q[3] & en_q[3]) | (stat_q[4] & en_q[4])) != 32'h0000_0000));
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low request without cause");

  property p_clear;
    acc_wr && st_idx == 3'h0 && pwdata_i[B_FRAME] && !frame_end_event_i |=> !stat_q[0][B_FRAME];
  endproperty
  a_clear: assert property (p_clear) else $error("clear write ignored");

  property p_sticky;
    stat_q[0][B_FRAME] && !(acc_wr && st_idx == 3'h0 && pwdata_i[B_FRAME]) |=> stat_q[0][B_FRAME];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost without clear");

  property p_gen_rst;
    $past(rst_i) |-> !gen_q && !cpu_int2_o;
  endproperty
  a_gen_rst: assert property (p_gen_rst) else $error("global enable set after reset");

  property p_stat_rst;
    $past(rst_i) |-> stat_q[0] == 32'h0000_0000;
  endproperty
  a_stat_rst: assert property (p_stat_rst) else $error("status not cleared by reset");

  property p_vec;
    prio_vec != 4'h0 |-> (gated_hp >> prio_vec) == 16'h0001;
  endproperty
  a_vec: assert property (p_vec) else $error("vector not highest pending");

  property p_links;
    ((mask_q[15:1] & hp_src_i) != 15'h0000) == cpu_int4_o && cop_cond3_o == cpu_int4_o
      && (!cpu_int4_o || irq_o);
  endproperty
  a_links: assert property (p_links) else $error("high request wiring wrong");

  property p_rx_word;
    tdm_input_half_a_event_i |=> rx_word_q == $past(hold_a_q);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("half A word not presented");

endmodule : iag_interrupt_aggregator
`default_nettype wire

// ---- sim/iag_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iag_cpu_model (
  // Clock
  input wire logic clock_i,
  // Core request lines
  input wire logic int4_i,
  input wire logic int2_i,
  input wire logic cond3_i,
  // Cause bits as the core latches them
  output logic [5:0] cause_o
);
  always_ff @(posedge clock_i) begin
    cause_o <= {cond3_i, int4_i, 1'b0, int2_i, 2'b00};
  end
endmodule : iag_cpu_model
`default_nettype wire

// ---- sim/tb_interrupt_aggregator.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_aggregator;
  import iag_pkg::*;
  logic clock_i, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lclk = 1'b0, rxv = 1'b0, rxh = 1'b0, ina = 1'b0, inb = 1'b0, dtake = 1'b0;
  logic pready, pslverr, er, int4, int2, cond3, irq, hr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rxw, rd, w, e;
  logic [8:0] ev = 9'h000;
  logic [19:5] oth = 15'h0000;
  logic [127:0] s25 = 128'h0;
  logic [3:0] pin = 4'h0, v;
  logic [7:0] rxb = 8'h00;
  logic [1:0] rxl = 2'h0;
  logic [15:1] hp = 15'h0000;
  logic [15:0] m;
  logic [5:0] cause;
  int n_fail = 0, n_compared = 0, cyc = 0;

  iag_interrupt_aggregator DUT (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .frame_end_event_i(ev[0]), .display_alternation_event_i(ev[1]),
    .tdm_buffer_half_event_i(ev[2]), .tdm_buffer_end_event_i(ev[3]),
    .tdm_pointer_step_event_i(ev[4]), .tdm_overrun_event_i(ev[5]),
    .audio_buffer_half_event_i(ev[6]), .audio_buffer_end_event_i(ev[7]),
    .voice_buffer_half_event_i(ev[8]), .set1_other_event_i(oth), .sets2_5_event_i(s25),
    .ext_pin_i(pin), .tdm_link_clock_i(lclk), .rx_byte_i(rxb), .rx_byte_valid_i(rxv),
    .rx_byte_lane_i(rxl), .rx_byte_half_b_i(rxh), .tdm_input_half_a_event_i(ina),
    .tdm_input_half_b_event_i(inb), .dma_rx_take_i(dtake), .tdm_rx_hold_word_o(rxw),
    .hp_src_i(hp), .cpu_int4_o(int4), .cpu_int2_o(int2), .cop_cond3_o(cond3), .irq_o(irq)
  );
  iag_cpu_model cpu (.clock_i(clock_i), .int4_i(int4), .int2_i(int2), .cond3_i(cond3), .cause_o(cause));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard, run needs a few hundred cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // No wait-state count assumed; loops until pready, the hang guard ends a stuck one
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask : rdc

  // Drops the event and half pulses one cycle after they were raised
  task tick;
    @(posedge clock_i);
    ev <= '0;
    oth <= '0;
    s25 <= '0;
    ina <= 1'b0;
    inb <= 1'b0;
  endtask : tick

  task rxload(input logic h, input logic [31:0] wd);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      rxb <= wd[8*i +: 8];
      rxl <= 2'(i);
      rxv <= 1'b1;
      rxh <= h;
    end
    @(posedge clock_i);
    rxv <= 1'b0;
    ina <= !h;
    inb <= h;
    tick();
    @(negedge clock_i);
    chk(rxw, wd);
  endtask : rxload

  function automatic logic [3:0] prio(input logic [15:0] mk, input logic [15:1] src);
    for (int k = 15; k >= 1; k--) begin
      if (mk[k] && src[k]) return 4'(k);
    end
    return 4'h0;
  endfunction : prio

  initial begin
    void'($urandom(32'h9428E6DC));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(STAT_BASE, 32'h0);
    rdc(CTRL_OFF, 32'h0);
    rdc(EN_BASE, 32'h0);
    $display("reset test done");
    w = $urandom();
    @(posedge clock_i);
    ev <= 9'h1FF;
    oth <= w[19:5];
    s25 <= {96'h0, w};
    tick();
    e = 32'hF8F0_0000 | (w & 32'h000F_FFE0);
    rdc(STAT_BASE, e);
    rdc(STAT_BASE + SET_STRIDE, w);
    apb(1'b1, STAT_BASE, 32'h0);
    rdc(STAT_BASE, e);
    apb(1'b1, STAT_BASE, w);
    rdc(STAT_BASE, e & ~w);
    apb(1'b1, STAT_BASE, 32'hFFFF_FFFF);
    $display("status test done");
    apb(1'b1, EN_BASE, 32'h8000_0000);
    rdc(EN_BASE, 32'h8000_0000);
    @(posedge clock_i);
    ev <= 9'h001;
    tick();
    @(negedge clock_i);
    chk(32'(int2), 32'h0);
    apb(1'b1, CTRL_OFF, 32'h8000_0000);
    @(negedge clock_i);
    chk(32'({int2, irq}), 32'h3);
    @(negedge clock_i);
    chk(32'(cause), 32'h4);
    rdc(CTRL_OFF, 32'hA000_0000);
    apb(1'b1, STAT_BASE, 32'h8000_0000);
    @(negedge clock_i);
    chk(32'(irq), 32'h0);
    $display("low request test done");
    @(posedge clock_i);
    for (int k = 0; k < 12; k++) begin
      m = (k == 0) ? 16'h8002 : (k == 1) ? 16'h0001 : 16'($urandom());
      hp <= (k == 0) ? 15'h0001 : (k == 1) ? 15'h7FFF : 15'($urandom());
      apb(1'b1, CTRL_OFF, {16'h0, m});
      @(negedge clock_i);
      v = prio(m, hp);
      hr = |({hp, 1'b0} & m);
      chk(32'({int4, cond3, irq}), 32'({hr, hr, hr}));
      @(negedge clock_i);
      chk(32'(cause), 32'({hr, hr, 4'h0}));
      rdc(CTRL_OFF, {1'b0, hr, 10'h0, v, m});
    end
    hp <= 15'h0000;
    $display("priority test done");
    @(posedge clock_i);
    pin <= 4'h1;
    lclk <= 1'b1;
    repeat (8) @(posedge clock_i);
    rdc(STAT_BASE + 12'h010, 32'h2);
    rdc(STAT_BASE, 32'h0100_0000);
    apb(1'b1, STAT_BASE + 12'h010, 32'hFFFF_FFFF);
    pin <= 4'h0;
    repeat (8) @(posedge clock_i);
    rdc(STAT_BASE + 12'h010, 32'h1);
    apb(1'b1, STAT_BASE, 32'hFFFF_FFFF);
    $display("pin test done");
    w = $urandom();
    e = $urandom();
    rxload(1'b0, w);
    rdc(RXHOLD_OFF, w);
    rxload(1'b1, e);
    rdc(RXHOLD_OFF, e);
    rdc(STAT_BASE, 32'h0600_0000);
    apb(1'b1, STAT_BASE, 32'hFFFF_FFFF);
    rxload(1'b0, w);
    rxload(1'b1, e);
    rdc(STAT_BASE, 32'h0680_0000);
    apb(1'b1, STAT_BASE, 32'hFFFF_FFFF);
    @(posedge clock_i);
    dtake <= 1'b1;
    @(posedge clock_i);
    dtake <= 1'b0;
    rxload(1'b0, w);
    rdc(STAT_BASE, 32'h0400_0000);
    $display("receive test done");
    apb(1'b0, 12'h200, 32'h0);
    chk({rd[31:1], er}, 32'h1);
    apb(1'b1, RXHOLD_OFF, 32'h1234_5678);
    chk(32'(er), 32'h0);
    rdc(RXHOLD_OFF, w);
    $display("refusal test done");
    @(posedge clock_i);
    ev <= 9'h1FF;
    tick();
    apb(1'b1, CTRL_OFF, 32'h8000_0000);
    @(posedge clock_i);
    rst_i <= 1'b1;
    @(negedge clock_i);
    chk(32'(irq), 32'h0);
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(STAT_BASE, 32'h0);
    rdc(CTRL_OFF, 32'h0);
    $display("second reset test done");
    end_sim();
  end
endmodule : tb_interrupt_aggregator
`default_nettype wire
